// >>> hdl/instruction_word_decoder.v
`include "instr_decode_consts.vh"

// What this block does
// - Take each instruction as one 14-bit word of opcode plus operands.
// - Byte ops send result to accumulator when target bit 0, except opcode 0x00 words, which write nothing; else file.
// - Register selector addresses file registers 0x00 to 0x7F.
// - Bit ops pick one bit of the addressed 8-bit file register.
// - Literal operand is eight or eleven bits depending on format.
// - Don't-care bits never change the decoded opcode.
// - One cycle per word; taken tests and jumps take two, second a no-op.
// - One instruction cycle is exactly four oscillator periods.
// - Byte words: opcode 13:8, target bit 7, selector 6:0.
// - Bit words: opcode 13:10, bit position 9:7, selector 6:0.
// - Jump words 13:11 opcode, 11-bit literal; others 8-bit literal.
module instruction_word_decoder (
   input  wire                      sys_clk_i,
   input  wire                      rst_n_i,
   input  wire [`WORD_W-1:0]        instr_i,
   input  wire                      cond_true_i,
   input  wire                      wdt_timeout_i,
   output reg                       fetch_o,
   output reg                       pc_load_o,
   output reg                       exec_valid_o,
   output reg                       flush_o,
   output reg  [1:0]                format_o,
   output reg  [`OPC_W-1:0]         opcode_o,
   output reg  [`REG_SEL_W-1:0]     reg_sel_o,
   output reg                       result_to_file_o,
   output reg                       result_to_acc_o,
   output reg  [`POS_W-1:0]         pos_in_word_o,
   output reg  [7:0]                bit_mask_o,
   output reg  [`LIT_LONG_W-1:0]    literal_const_o,
   output reg                       sleep_o,
   output reg                       watchdog_expired_o,
   output reg                       sleep_entered_o,
   output wire [`PHASE_W-1:0]       cycle_phase_o
);

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   reg        rst_s1_reg;
   reg        rst_s2_reg;
   wire       rst_n;

   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end

   assign rst_n = rst_s2_reg;

   // ------------------------------------------------------------
   // Cycle timing
   // ------------------------------------------------------------
   wire       cycle_end;

   cycle_phase_gen u_phase (
      .sys_clk_i   (sys_clk_i),
      .rst_n_i     (rst_n),
      .phase_o     (cycle_phase_o),
      .cycle_end_o (cycle_end)
   );

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function [1:0] word_format;
      input [`WORD_W-1:0] w;
      begin
         case (w[13:12])
            `CLS_BYTE: word_format = `FMT_BYTE;
            `CLS_BIT:  word_format = `FMT_BIT;
            `CLS_LONG: word_format = `FMT_LONG;
            default:   word_format = `FMT_LIT;
         endcase
      end
   endfunction

   // Skip-type word: second cycle only if test true
   function is_skip;
      input [`WORD_W-1:0] w;
      begin
         is_skip =
            (w[13:8] == `BYTE_DEC_SKIP) ||
            (w[13:8] == `BYTE_INC_SKIP) ||
            (w[13:10] == `BIT_TEST_CLR) ||
            (w[13:10] == `BIT_TEST_SET);
      end
   endfunction

   // Word that always changes the program counter
   function is_jump;
      input [`WORD_W-1:0] w;
      begin
         is_jump =
            (w[13:12] == `CLS_LONG) ||
            (w[13:10] == `LIT_RET_HI) ||
            (w == `WORD_RETURN) ||
            (w == `WORD_RETINT);
      end
   endfunction

   // Opcode with don't-care positions forced to zero
   function [`OPC_W-1:0] opcode_of;
      input [`WORD_W-1:0] w;
      begin
         case (word_format(w))
            `FMT_BYTE: opcode_of = w[`BYTE_OPC_HI:`BYTE_OPC_LO];
            `FMT_BIT:  opcode_of = {2'h0, w[`BIT_OPC_HI:`BIT_OPC_LO]};
            `FMT_LONG: opcode_of = {3'h0, w[13:`LONG_OPC_LO]};
            default: begin
               // Upper literal group ignores bits 9:8 or bit 8
               if (w[11] == 1'b0)
                  opcode_of = {w[13:10], 2'h0};
               else if (w[10:9] != 2'h0)
                  opcode_of = {w[13:9], 1'b0};
               else
                  opcode_of = w[13:8];
            end
         endcase
      end
   endfunction

   // ------------------------------------------------------------
   // Executing word and two-cycle control
   // ------------------------------------------------------------
   reg                    skip_reg;
   reg                    jump_reg;
   reg                    sleep_word_reg;
   reg                    wdt_clr_word_reg;
   wire                   second_cycle;
   wire [`WORD_W-1:0]     next_word;
   wire [1:0]             nfmt;
   wire                   byte_dest;
   wire                   ctrl_zero;

   // A taken test or a jump turns the next cycle into a no-op
   assign second_cycle = exec_valid_o &
                         (jump_reg | (skip_reg & cond_true_i));
   // Prefetched word dropped when the second cycle is due
   assign next_word = second_cycle ? `WORD_NOP : instr_i;
   assign nfmt      = word_format(next_word);
   assign byte_dest = next_word[`BYTE_DEST_BIT];
   // Control words in the zero-opcode group write nothing
   assign ctrl_zero = (next_word[13:8] == `BYTE_MOVE_W) & ~byte_dest;

   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fetch_o          <= 1'b0;
         pc_load_o        <= 1'b0;
         exec_valid_o     <= 1'b0;
         flush_o          <= 1'b0;
         format_o         <= `FMT_BYTE;
         opcode_o         <= {`OPC_W{1'b0}};
         reg_sel_o        <= {`REG_SEL_W{1'b0}};
         result_to_file_o <= 1'b0;
         result_to_acc_o  <= 1'b0;
         pos_in_word_o    <= {`POS_W{1'b0}};
         bit_mask_o       <= 8'h00;
         literal_const_o  <= {`LIT_LONG_W{1'b0}};
         skip_reg         <= 1'b0;
         jump_reg         <= 1'b0;
         sleep_word_reg   <= 1'b0;
         wdt_clr_word_reg <= 1'b0;
      end else begin
         fetch_o   <= cycle_end;
         pc_load_o <= cycle_end & second_cycle;
         if (cycle_end) begin
            exec_valid_o     <= ~second_cycle;
            flush_o          <= second_cycle;
            format_o         <= nfmt;
            opcode_o         <= opcode_of(next_word);
            reg_sel_o        <= next_word[`REG_SEL_HI:0];
            result_to_file_o <= (nfmt == `FMT_BYTE) & byte_dest;
            result_to_acc_o  <= (nfmt == `FMT_BYTE) & ~byte_dest &
                                ~ctrl_zero;
            pos_in_word_o    <= next_word[`BIT_POS_HI:`BIT_POS_LO];
            bit_mask_o       <= 8'h01 <<
                                next_word[`BIT_POS_HI:`BIT_POS_LO];
            if (nfmt == `FMT_LONG)
               literal_const_o <= next_word[`LIT_LONG_HI:0];
            else
               literal_const_o <= {3'h0,
                                   next_word[`LIT_SHORT_W-1:0]};
            skip_reg         <= is_skip(next_word);
            jump_reg         <= is_jump(next_word);
            sleep_word_reg   <= (next_word == `WORD_SLEEP);
            wdt_clr_word_reg <= (next_word == `WORD_WDT_CLR);
         end
      end
   end

   // ------------------------------------------------------------
   // Status bits
   // ------------------------------------------------------------
   wire       wdt_s1;
   reg        wdt_s1_reg;
   reg        wdt_s2_reg;
   reg        wdt_s3_reg;
   reg        wdt_seen_reg;
   wire       wdt_event;

   assign wdt_s1 = wdt_s1_reg;

   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         wdt_s1_reg   <= 1'b0;
         wdt_s2_reg   <= 1'b0;
         wdt_s3_reg   <= 1'b0;
         wdt_seen_reg <= 1'b0;
      end else begin
         wdt_s1_reg <= wdt_timeout_i;
         wdt_s2_reg <= wdt_s1;
         wdt_s3_reg <= wdt_s2_reg;
         if (wdt_s2_reg == wdt_s3_reg)
            wdt_seen_reg <= wdt_s3_reg;
      end
   end

   assign wdt_event = (wdt_s2_reg == wdt_s3_reg) & wdt_s3_reg &
                      ~wdt_seen_reg;

   // Instructions act at the end of their cycle
   always @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_expired_o <= `STAT_RESET;
         sleep_entered_o    <= `STAT_RESET;
         sleep_o            <= 1'b0;
      end else begin
         if (cycle_end & exec_valid_o & wdt_clr_word_reg) begin
            watchdog_expired_o <= 1'b0;
            sleep_entered_o    <= 1'b0;
         end
         if (cycle_end & exec_valid_o & sleep_word_reg) begin
            watchdog_expired_o <= 1'b0;
            sleep_entered_o    <= 1'b1;
            sleep_o            <= 1'b1;
         end
         // Timeout wins over a same-cycle clear and ends sleep
         if (wdt_event) begin
            watchdog_expired_o <= 1'b1;
            sleep_o            <= 1'b0;
         end
      end
   end

endmodule

// >>> hdl/instr_decode_consts.vh
`ifndef INSTR_DECODE_CONSTS_VH
`define INSTR_DECODE_CONSTS_VH

// ---------------------------------------------------------------
// Word layout
// ---------------------------------------------------------------
`define WORD_W          14
`define REG_SEL_W       7
`define POS_W           3
`define LIT_LONG_W      11
`define LIT_SHORT_W     8
`define OPC_W           6
`define PHASES          4
`define PHASE_W         2
`define PHASE_LAST      2'h3
`define REG_SEL_MAX     7'h7F

`define BYTE_OPC_HI     13
`define BYTE_OPC_LO     8
`define BYTE_DEST_BIT   7
`define BIT_OPC_HI      13
`define BIT_OPC_LO      10
`define BIT_POS_HI      9
`define BIT_POS_LO      7
`define REG_SEL_HI      6
`define LONG_OPC_LO     11
`define LIT_LONG_HI     10

// ---------------------------------------------------------------
// Format codes
// ---------------------------------------------------------------
`define FMT_BYTE        2'h0
`define FMT_BIT         2'h1
`define FMT_LIT         2'h2
`define FMT_LONG        2'h3

// ---------------------------------------------------------------
// Class prefixes and special words
// ---------------------------------------------------------------
`define CLS_BYTE        2'h0
`define CLS_BIT         2'h1
`define CLS_LONG        2'h2
`define CLS_LIT         2'h3
`define BIT_TEST_CLR    4'h6
`define BIT_TEST_SET    4'h7
`define BYTE_DEC_SKIP   6'h0B
`define BYTE_INC_SKIP   6'h0F
`define BYTE_MOVE_W     6'h00
`define BYTE_CLEAR      6'h01
`define LIT_RET_HI      4'hD
`define WORD_RETURN     14'h0008
`define WORD_RETINT     14'h0009
`define WORD_SLEEP      14'h0063
`define WORD_WDT_CLR    14'h0064
`define WORD_NOP        14'h0000

`define STAT_RESET      1'h0

`endif

// >>> hdl/cycle_phase_gen.v
`include "instr_decode_consts.vh"

module cycle_phase_gen (
   input  wire                  sys_clk_i,
   input  wire                  rst_n_i,
   output reg  [`PHASE_W-1:0]   phase_o,
   output reg                   cycle_end_o
);

   // ------------------------------------------------------------
   // Four oscillator periods make one instruction cycle
   // ------------------------------------------------------------
   always @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_o     <= {`PHASE_W{1'b0}};
         cycle_end_o <= 1'b0;
      end else begin
         phase_o     <= phase_o + 2'h1;
         cycle_end_o <= (phase_o == `PHASE_LAST - 2'h1);
      end
   end

endmodule

// >>> test/instruction_word_decoder_chk.sv
module instruction_word_decoder_chk (
   input wire        sys_clk_i,
   input wire        rst_n_i,
   input wire        wdt_timeout_i,
   input wire        fetch_o,
   input wire        pc_load_o,
   input wire        exec_valid_o,
   input wire        flush_o,
   input wire [1:0]  format_o,
   input wire [5:0]  opcode_o,
   input wire        result_to_file_o,
   input wire        result_to_acc_o,
   input wire [2:0]  pos_in_word_o,
   input wire [7:0]  bit_mask_o,
   input wire [10:0] literal_const_o,
   input wire        watchdog_expired_o,
   input wire [1:0]  cycle_phase_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_period; fetch_o |=> !fetch_o [*3] ##1 fetch_o; endproperty
   a_period: assert property (p_period) else $error("fetch spacing");
   property p_phase; fetch_o |-> cycle_phase_o == 2'h0; endproperty
   a_phase: assert property (p_phase) else $error("fetch phase");
   property p_dest;
      result_to_file_o |-> format_o == 2'h0 && !result_to_acc_o;
   endproperty
   a_dest: assert property (p_dest) else $error("target");
   property p_mask;
      exec_valid_o |-> bit_mask_o == 8'h01 << pos_in_word_o;
   endproperty
   a_mask: assert property (p_mask) else $error("bit mask");
   property p_lit;
      exec_valid_o && format_o != 2'h3 |-> literal_const_o[10:8] == 3'h0;
   endproperty
   a_lit: assert property (p_lit) else $error("literal width");
   property p_flush; pc_load_o |-> fetch_o && flush_o; endproperty
   a_flush: assert property (p_flush) else $error("reload");
   property p_noop;
      flush_o |-> !exec_valid_o && opcode_o == 6'h00 && !result_to_file_o;
   endproperty
   a_noop: assert property (p_noop) else $error("no-op");
   property p_hold;
      !fetch_o |-> $stable(opcode_o) && $stable(literal_const_o);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_wdt;
      $rose(wdt_timeout_i) |-> ##[2:6] watchdog_expired_o;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog");
endmodule

bind instruction_word_decoder instruction_word_decoder_chk u_chk (.*);

// >>> test/prog_mem_model.sv
module prog_mem_model (
   input  wire         sys_clk_i,
   input  wire  [1:0]  phase_i,
   input  wire  [13:0] next_word_i,
   output logic [13:0] word_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial word_o = 14'h0000;
   // Word valid only across the take edge, scrambled elsewhere
   always @(negedge sys_clk_i)
      if (phase_i == 2'h3)
         word_o <= next_word_i;
      else
         word_o <= ~word_o;
endmodule

// >>> test/tb_instruction_word_decoder.sv
module tb_instruction_word_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [13:0] nw = 14'h0000;
   logic [13:0] instr;
   logic        cond = 1'b0;
   logic        cn = 1'b0;
   logic        wdt = 1'b0;
   logic        fetch, pcl, exv, fls, tf, ta, slp, wex, sen, fl = 1'b0;
   logic [1:0]  fmt, ph;
   logic [5:0]  opc;
   logic [6:0]  rs;
   logic [2:0]  pos;
   logic [7:0]  msk;
   logic [10:0] lit;
   logic [31:0] r;
   logic [83:0] q[$];
   int          error_cnt = 0;
   int          check_count = 0;
   int          seed = 62;
   logic [14:0] dir [16] = '{15'h077F, 15'h07FF, 15'h1780, 15'h5800,
      15'h3FFF, 15'h0B80, 15'h4F80, 15'h0000, 15'h2FFF, 15'h2000,
      15'h30A5, 15'h33A5, 15'h34FF, 15'h0008, 15'h0009, 15'h0000};

   always #4 sys_clk_i = ~sys_clk_i;

   prog_mem_model u_mem (.sys_clk_i(sys_clk_i), .phase_i(ph),
      .next_word_i(nw), .word_o(instr));

   instruction_word_decoder uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .instr_i(instr), .cond_true_i(cond), .wdt_timeout_i(wdt),
      .fetch_o(fetch), .pc_load_o(pcl), .exec_valid_o(exv), .flush_o(fls),
      .format_o(fmt), .opcode_o(opc), .reg_sel_o(rs),
      .result_to_file_o(tf), .result_to_acc_o(ta), .pos_in_word_o(pos),
      .bit_mask_o(msk), .literal_const_o(lit), .sleep_o(slp),
      .watchdog_expired_o(wex), .sleep_entered_o(sen),
      .cycle_phase_o(ph));

   task automatic test_done;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic bad(input string s);
      error_cnt++;
      $display("BAD %0t %s", $time, s);
   endtask

   task automatic chk(input logic ok, input string s);
      check_count++;
      if (ok !== 1'b1)
         bad(s);
   endtask

   function automatic logic [41:0] dec(input logic [13:0] w);
      logic [1:0] f;
      logic [5:0] o;
      f = w[13:12] == 2'h2 ? 2'h3 : w[13:12] == 2'h3 ? 2'h2 : w[13:12];
      o = f == 2'h1 ? {2'h0, w[13:10]} : w[13:8];
      if (f == 2'h3)
         o = {3'h0, w[13:11]};
      if (w[13:11] == 3'h6)
         o[1:0] = 2'h0;
      if (w[13:11] == 3'h7 && w[10:9] != 2'h0)
         o[0] = 1'b0;
      dec = {3'h2, f, o, w[6:0], f == 2'h0 && w[7],
             f == 2'h0 && !w[7] && o != 6'h00, w[9:7], 8'h01 << w[9:7],
             f == 2'h3 ? w[10:0] : {3'h0, w[7:0]}};
   endfunction

   // Hands one word to the memory model, notes what the decoder must show
   task automatic put(input logic [13:0] w, input logic c);
      logic [41:0] e;
      logic        j;
      int          n;
      n = 0;
      do begin
         @(negedge sys_clk_i);
         n++;
      end while (ph !== 2'h1 && n < 20);
      if (n >= 20) begin
         bad("no cycle");
         test_done;
      end else begin
         nw = w;
         // Test result of the executing word, taken with the next one
         cond = cn;
         cn = c;
         e = dec(w);
         j = e[38:37] == 2'h3 || w == 14'h0008 || w == 14'h0009 ||
             w[13:10] == 4'hD || c && (w[13:8] == 6'h0B ||
             w[13:8] == 6'h0F || w[13:11] == 3'h3);
         if (fl)
            q.push_back({42'h39F_80C0_0000, 42'h280_0000_0000});
         else
            q.push_back({42'h3FF_FFFF_FFFF, e});
         fl = j && !fl;
      end
   endtask

   always @(negedge sys_clk_i) begin
      logic [83:0] x;
      if (fetch === 1'b1) begin
         check_count++;
         if (q.size() == 0)
            bad("stray fetch");
         else begin
            x = q.pop_front();
            if ((({pcl, exv, fls, fmt, opc, rs, tf, ta, pos, msk, lit} ^
                x[41:0]) & x[83:42]) !== 42'h0)
               bad("decode");
         end
      end
   end

   initial begin
      repeat (4) @(negedge sys_clk_i);
      rst_n_i = 1'b1;
      for (int i = 0; i < 16; i++)
         put(dir[i][13:0], dir[i][14]);
      for (int i = 0; i < 48; i++) begin
         r = $random(seed);
         put(r[13:0], r[20]);
      end
      put(14'h0000, 1'b0);
      put(14'h0063, 1'b0);
      repeat (2) put(14'h0000, 1'b0);
      chk(sen & slp, "sleep status");
      wdt = 1'b1;
      repeat (3) put(14'h0000, 1'b0);
      chk(wex & !slp, "watchdog status");
      put(14'h0064, 1'b0);
      repeat (2) put(14'h0000, 1'b0);
      chk(!wex & !sen, "clear status");
      for (int i = 0; i < 10 && q.size() > 0; i++)
         @(negedge sys_clk_i);
      if (q.size() > 0)
         bad("missing fetch");
      test_done;
   end
endmodule
